/* rtl/slac_top.sv */
// serial line arbiter counter: bit time measurement, bus arbitration, AXI4-Lite registers
// ----------------------------------------------------------------
// Summary of operation
// - nine-bit counter with separate overflow bit, run by a mode field in control.
// - mode 00 idle and reset, 01 bit time measure, 10 arbitration, 11 reserved.
// - reset clears mode, clock select, all status flags and the counter msb.
// - arbitration-lost flag is read-only, cleared only by writing zero to upper mode bit.
// - clock select 1 counts at half prescaler rate, 0 counts at bus clock over four.
// - prescaler input comes from bus or crystal clock per baud source bit.
// - measure-done flag sets when a measurement ends; any control write clears it.
// - running flag reads one while counting, zero while stopped.
// - overflow flag sets when the counter wraps; any control write clears it.
// - mode 00 resets the counter and holds it idle while selected.
// - counter msb reads in control register; any control write clears it.
// - low eight counter bits read in data register; control write clears them.
// - measure, select 0: start at receive falling edge, stop at next falling edge.
// - measure, select 1: start while receive is low, stop at next rising edge.
// - arbitration: restart on transmit rise, sample receive at 0x38/0x08; low sets lost.
// ----------------------------------------------------------------
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module slac_top
  import slac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_pin,
  input wire logic internal_transmit_output,
  input wire logic presc_tick_bus,
  input wire logic presc_tick_xtal,
  output logic tx_pin,
  output logic irq
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == OFS_CTL) || (a == OFS_CNT_LOW) || (a == OFS_IRQ_STAT) ||
                  (a == OFS_IRQ_CLR) || (a == OFS_IRQ_EN) || (a == OFS_SYS_CFG);
  endfunction : addr_mapped

  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
  wire wr_lane0 = do_write && wstrb_q[0];
  wire ctl_wr = wr_lane0 && (awaddr_q == OFS_CTL);
  wire clr_wr = wr_lane0 && (awaddr_q == OFS_IRQ_CLR);
  wire en_wr = wr_lane0 && (awaddr_q == OFS_IRQ_EN);
  wire cfg_wr = wr_lane0 && (awaddr_q == OFS_SYS_CFG);
  wire rd_take = s_axi_arvalid && !rvalid_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= RD_ZERO;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin synchroniser, edge detection and clock enables
  // ----------------------------------------------------------------
  logic rx_meta_q, rx_s_q, rx_d_q, tx_d_q, half_q;
  logic [1:0] bus_div_q;
  logic baud_src_q, clk_sel_q;

  wire rx_fall = rx_d_q && !rx_s_q;
  wire rx_rise = !rx_d_q && rx_s_q;
  wire tx_rise = !tx_d_q && internal_transmit_output;
  wire bus_tick = (bus_div_q == BUS_DIV_LAST);
  wire presc_tick = baud_src_q ? presc_tick_xtal : presc_tick_bus;
  wire half_tick = presc_tick && half_q;
  wire cnt_tick = clk_sel_q ? half_tick : bus_tick;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rx_meta_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_d_q <= 1'b1;
      tx_d_q <= 1'b1;
      bus_div_q <= 2'h0;
      half_q <= 1'b0;
    end
    else
    begin
      rx_meta_q <= rx_pin;
      rx_s_q <= rx_meta_q;
      rx_d_q <= rx_s_q;
      tx_d_q <= internal_transmit_output;
      bus_div_q <= bus_div_q + 2'h1;
      if (presc_tick)
        half_q <= !half_q;
    end
  end

  // ----------------------------------------------------------------
  // counter and mode control
  // ----------------------------------------------------------------
  slac_mode_e mode_q;
  slac_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic lost_q, done_q, ovf_q, done_set, ovf_set, lost_set;

  wire running = (st_q == ST_RUN);
  wire [CNT_W-1:0] arb_target = clk_sel_q ? ARB_TARGET_PRESC : ARB_TARGET_BUS;
  wire meas_start = clk_sel_q ? !rx_s_q : rx_fall;
  wire meas_stop = clk_sel_q ? rx_rise : rx_fall;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    done_set = 1'b0;
    ovf_set = 1'b0;
    lost_set = 1'b0;
    if (running && cnt_tick)
    begin
      cnt_d = cnt_q + 9'h001;
      ovf_set = (cnt_q == CNT_MAX);
    end
    case (mode_q)
      MODE_MEAS:
      begin
        if (st_q == ST_IDLE && meas_start)
        begin
          st_d = ST_RUN;
          cnt_d = CNT_RST;
        end
        else if (running && meas_stop)
        begin
          st_d = ST_STOP;
          done_set = 1'b1;
        end
      end
      MODE_ARB:
      begin
        if (tx_rise)
        begin
          st_d = ST_RUN;
          cnt_d = CNT_RST;
          ovf_set = 1'b0;
        end
        else if (running && !internal_transmit_output)
        begin
          st_d = ST_IDLE;
          cnt_d = CNT_RST;
          ovf_set = 1'b0;
        end
        else if (running && cnt_q == arb_target)
        begin
          st_d = ST_STOP;
          cnt_d = cnt_q;
          ovf_set = 1'b0;
          lost_set = !rx_s_q;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
        cnt_d = CNT_RST;
        ovf_set = 1'b0;
      end
    endcase
    if (ctl_wr)
    begin
      st_d = ST_IDLE;
      cnt_d = CNT_RST;
    end
  end

  // ----------------------------------------------------------------
  // registers; a flag set in the cycle of its clear stays set
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_st_q, irq_en_q;
  wire [IRQ_W-1:0] irq_set = {lost_set, ovf_set, done_set};
  wire [IRQ_W-1:0] irq_clr = clr_wr ? wdata_q[IRQ_W-1:0] : IRQ_RST;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_q <= MODE_IDLE;
      clk_sel_q <= 1'b0;
      lost_q <= 1'b0;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
      st_q <= ST_IDLE;
      cnt_q <= CNT_RST;
      baud_src_q <= 1'b0;
      irq_st_q <= IRQ_RST;
      irq_en_q <= IRQ_RST;
      tx_pin <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (ctl_wr)
      begin
        mode_q <= slac_mode_e'(wdata_q[CTL_MODE_HI:CTL_MODE_LO]);
        clk_sel_q <= wdata_q[CTL_CLK_SEL];
      end
      lost_q <= lost_set || (lost_q && !(ctl_wr && !wdata_q[CTL_MODE_HI]));
      done_q <= done_set || (done_q && !ctl_wr);
      ovf_q <= ovf_set || (ovf_q && !ctl_wr);
      if (cfg_wr)
        baud_src_q <= wdata_q[CFG_BAUD_SRC];
      if (en_wr)
        irq_en_q <= wdata_q[IRQ_W-1:0];
      irq_st_q <= irq_set | (irq_st_q & ~irq_clr);
      // reserved mode keeps the transmit path clean even with a stale lost flag
      tx_pin <= internal_transmit_output || (lost_q && mode_q != MODE_RSVD);
      irq <= |(irq_st_q & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] ctl_rd = {mode_q, lost_q, clk_sel_q, done_q, running, ovf_q, cnt_q[8]};
  logic [31:0] rd_mux;

  always_comb
  begin
    case (s_axi_araddr)
      OFS_CTL: rd_mux = {24'h00_0000, ctl_rd};
      OFS_CNT_LOW: rd_mux = {24'h00_0000, cnt_q[7:0]};
      OFS_IRQ_STAT: rd_mux = {29'h0000_0000, irq_st_q};
      OFS_IRQ_EN: rd_mux = {29'h0000_0000, irq_en_q};
      OFS_SYS_CFG: rd_mux = {31'h0000_0000, baud_src_q};
      default: rd_mux = RD_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= RD_ZERO;
      rresp_q <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_cnt_width;
    running && cnt_tick && cnt_q == CNT_MAX && mode_q == MODE_MEAS && !ctl_wr && !meas_stop
      |=> cnt_q == CNT_RST && ovf_q;
  endproperty
  a_cnt_width: assert property (p_cnt_width) else $error("counter wrap lost");

  property p_idle_hold;
    (mode_q == MODE_IDLE) [*2] |-> cnt_q == CNT_RST && !running;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle mode counter not held");

  // the default disable would mask every attempt, since the antecedent is reset itself
  property p_reset_clear;
    @(posedge sys_clk) disable iff (1'b0)
      rst |=> mode_q == MODE_IDLE && !clk_sel_q && !lost_q && !done_q && !ovf_q && !cnt_q[8];
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");

  property p_lost_fall;
    $fell(lost_q) |-> $past(ctl_wr && !wdata_q[CTL_MODE_HI]);
  endproperty
  a_lost_fall: assert property (p_lost_fall) else $error("lost cleared wrongly");

  property p_lost_rise;
    $rose(lost_q) |-> $past(mode_q == MODE_ARB && running && cnt_q == arb_target && !rx_s_q);
  endproperty
  a_lost_rise: assert property (p_lost_rise) else $error("lost set wrongly");

  property p_bus_rate;
    !clk_sel_q && bus_tick |=> !bus_tick [*3] ##1 bus_tick;
  endproperty
  a_bus_rate: assert property (p_bus_rate) else $error("bus divide by four wrong");

  property p_done_clear;
    ctl_wr && !done_set && !ovf_set |=> !done_q && !ovf_q && cnt_q == CNT_RST;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("control write no clear");

  property p_fall_start;
    mode_q == MODE_MEAS && !clk_sel_q && st_q == ST_IDLE && rx_fall && !ctl_wr |=> running;
  endproperty
  a_fall_start: assert property (p_fall_start) else $error("falling edge start lost");

  property p_low_start;
    mode_q == MODE_MEAS && clk_sel_q && st_q == ST_IDLE && !rx_s_q && !ctl_wr |=> running;
  endproperty
  a_low_start: assert property (p_low_start) else $error("low level start lost");

  property p_tx_force;
    lost_q && mode_q != MODE_RSVD |=> tx_pin;
  endproperty
  a_tx_force: assert property (p_tx_force) else $error("transmit not forced high");

  property p_rsvd_idle;
    (mode_q == MODE_RSVD) [*2] |-> !running && cnt_q == CNT_RST;
  endproperty
  a_rsvd_idle: assert property (p_rsvd_idle) else $error("reserved mode counts");

  property p_run_flag;
    $rose(running) |-> $past(mode_q == MODE_MEAS || mode_q == MODE_ARB);
  endproperty
  a_run_flag: assert property (p_run_flag) else $error("running in idle mode");

  property p_src_sel;
    !rst && baud_src_q && clk_sel_q && presc_tick_xtal && half_q |-> cnt_tick;
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("crystal prescaler not used");

endmodule : slac_top

/* rtl/slac_pkg.sv */
// package: register map, field layout and constants of the serial line arbiter counter
package slac_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CNT_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SYS_CFG = 8'h14;

  // ----------------------------------------------------------------
  // arbiter_control_status field positions
  // ----------------------------------------------------------------
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_LOST = 5;
  localparam int CTL_CLK_SEL = 4;
  localparam int CTL_DONE = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_OVF = 1;
  localparam int CTL_MSB = 0;
  localparam int CFG_BAUD_SRC = 0;

  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_LOST = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // counter, divider and reset values
  // ----------------------------------------------------------------
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
  localparam logic [CNT_W-1:0] CNT_MAX = 9'h1FF;
  localparam logic [CNT_W-1:0] ARB_TARGET_BUS = 9'h038;
  localparam logic [CNT_W-1:0] ARB_TARGET_PRESC = 9'h008;
  localparam logic [1:0] BUS_DIV_LAST = 2'h3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_MEAS = 2'h1,
    MODE_ARB = 2'h2,
    MODE_RSVD = 2'h3
  } slac_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_STOP = 3'b100
  } slac_state_e;

endpackage : slac_pkg

/* tb/slac_bus_node.sv */
// model of the shared single-wire bus: other node, pull-up and wired-AND
`timescale 1ns/1ps
module slac_bus_node (
  input wire logic drive_low,
  input wire logic node_tx,
  output logic bus_line
);
  // pulled up, so a released line reads recessive high
  assign bus_line = node_tx & ~drive_low;
endmodule : slac_bus_node

/* tb/tb_top.sv */
// self-checking testbench of the serial line arbiter counter
`timescale 1ns/1ps
module tb_top
  import slac_pkg::*;
;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00;
  logic [ADDR_W-1:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic itx = 1'h1, dom = 1'h0, presc_tick_bus = 1'h0, presc_tick_xtal = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rx_pin, tx_pin, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int error_cnt = 0, cmp_count = 0, tdiv = 0;

  always #2.5 sys_clk = ~sys_clk;

  slac_top slac_top_inst (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_pin, .internal_transmit_output(itx), .presc_tick_bus,
    .presc_tick_xtal, .tx_pin, .irq);

  slac_bus_node slac_bus_node_inst (.drive_low(dom), .node_tx(tx_pin), .bus_line(rx_pin));

  // prescaler pulses: bus one every 3 cycles, crystal one every 4
  always @(posedge sys_clk)
  begin
    tdiv <= (tdiv == 11) ? 0 : tdiv + 1;
    presc_tick_bus <= (tdiv % 3 == 0);
    presc_tick_xtal <= (tdiv % 4 == 0);
  end

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic hang();
    chk(32'h0000_0000, 32'h0000_0001);
    close_out();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
        break;
    end
    if (n == 64)
      hang();
    chk(32'(s_axi_bresp), 32'(RESP_OKAY));
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
        break;
    end
    if (n == 64)
      hang();
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'h0;
  endtask : rd

  // one low pulse on the bus from the other node: a falling then a rising edge
  task automatic pulse();
    @(posedge sys_clk);
    dom <= 1'h1;
    repeat (6) @(posedge sys_clk);
    dom <= 1'h0;
  endtask : pulse

  // count within two of cycles over ticks, modulo the nine-bit range
  function automatic logic near(input logic [8:0] got, input int cyc, input int per);
    int g;
    int e;
    if ($isunknown(got))
      return 1'h0;
    g = int'(got);
    e = (cyc / per) % 512;
    return ((g - e + 512) % 512 <= 2) || ((e - g + 512) % 512 <= 2);
  endfunction : near

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] v;
    logic [31:0] c;
    int p;
    void'($urandom(32'he9d8));
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    wr(OFS_CNT_LOW, 32'h0000_00FF);
    wr(OFS_CTL, 32'h0000_002F);
    for (int a = 0; a <= 24; a += 4)
    begin
      rd(8'(a), (a == 24) ? RESP_SLVERR : RESP_OKAY, v);
      chk(v, RD_ZERO);
    end
    $display("test reset and access done");
    wr(OFS_IRQ_EN, 32'h0000_0007);
    for (int i = 0; i < 3; i++)
    begin
      p = (i == 0) ? 60 + $urandom % 900 : (i == 1) ? 1100 + $urandom % 500 : 2200 + $urandom % 300;
      wr(OFS_CTL, 32'h0000_0040);
      pulse();
      rd(OFS_CTL, RESP_OKAY, v);
      chk(v & 32'h0000_0004, 32'h0000_0004);
      repeat (p - 11) @(posedge sys_clk);
      pulse();
      repeat (4) @(posedge sys_clk);
      rd(OFS_CTL, RESP_OKAY, c);
      chk(c & 32'h0000_000E, (p >= 2048) ? 32'h0000_000A : 32'h0000_0008);
      rd(OFS_CNT_LOW, RESP_OKAY, v);
      chk(32'(near({c[0], v[7:0]}, p, 4)), 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      wr(OFS_IRQ_CLR, 32'h0000_0007);
      repeat (2) @(posedge sys_clk);
      chk(32'(irq), 32'h0000_0000);
      wr(OFS_CTL, 32'h0000_0040);
      rd(OFS_CTL, RESP_OKAY, v);
      chk(v, 32'h0000_0040);
      rd(OFS_CNT_LOW, RESP_OKAY, v);
      chk(v, RD_ZERO);
    end
    $display("test measurement on bus clock done");
    for (int s = 0; s < 2; s++)
    begin
      wr(OFS_SYS_CFG, 32'(s));
      wr(OFS_CTL, 32'h0000_0000);
      dom <= 1'h1;
      p = 200 + $urandom % 1000;
      repeat (4) @(posedge sys_clk);
      wr(OFS_CTL, 32'h0000_0050);
      repeat (p) @(posedge sys_clk);
      dom <= 1'h0;
      repeat (5) @(posedge sys_clk);
      rd(OFS_CTL, RESP_OKAY, c);
      chk(c & 32'h0000_000E, 32'h0000_0008);
      rd(OFS_CNT_LOW, RESP_OKAY, v);
      chk(32'(near({c[0], v[7:0]}, p, (s == 1) ? 8 : 6)), 32'h0000_0001);
    end
    $display("test measurement on prescaler done");
    for (int s = 0; s < 2; s++)
    begin
      itx <= 1'h0;
      dom <= 1'h1;
      wr(OFS_CTL, (s == 1) ? 32'h0000_0090 : 32'h0000_0080);
      p = (s == 1) ? 64 : 224;
      itx <= 1'h1;
      repeat (p - 24) @(posedge sys_clk);
      rd(OFS_CTL, RESP_OKAY, v);
      chk(v & 32'h0000_0024, 32'h0000_0004);
      repeat (40) @(posedge sys_clk);
      rd(OFS_CTL, RESP_OKAY, v);
      chk(v & 32'h0000_0024, 32'h0000_0020);
      itx <= 1'h0;
      repeat (3) @(posedge sys_clk);
      chk(32'(tx_pin), 32'h0000_0001);
      wr(OFS_CTL, 32'h0000_00C0);
      repeat (3) @(posedge sys_clk);
      chk(32'(tx_pin), 32'h0000_0000);
      rd(OFS_CTL, RESP_OKAY, v);
      chk(v & 32'h0000_00FF, 32'h0000_00E0);
      wr(OFS_CTL, 32'h0000_0000);
      dom <= 1'h0;
      pulse();
      pulse();
      rd(OFS_CTL, RESP_OKAY, v);
      chk(v, RD_ZERO);
      rd(OFS_CNT_LOW, RESP_OKAY, v);
      chk(v, RD_ZERO);
    end
    $display("test arbitration, reserved and idle done");
    close_out();
  end
endmodule : tb_top
